/* File: hw/maoi_pkg.sv */
// shared constants and carriers for the accumulator / file-register execute block
package maoi_pkg;

  // instruction word geometry
  localparam int INSN_W   = 14;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 7;

  // field positions inside the instruction word
  localparam int DIR_BIT  = 7;
  localparam int LIT_LSB  = 0;
  localparam int ADDR_LSB = 0;

  // literal load: top nibble 11 00, the next two bits are don't care
  localparam int          LIT_OPC_LSB = 10;
  localparam logic [3:0]  LIT_OPC     = 4'hC;
  // or-with-file and move-file: top six bits
  localparam int          REG_OPC_LSB = 8;
  localparam logic [5:0]  OR_OPC      = 6'h04;
  localparam logic [5:0]  MOV_OPC     = 6'h08;
  // store accumulator: top seven bits 00 0000 1
  localparam int          STO_OPC_LSB = 7;
  localparam logic [6:0]  STO_OPC     = 7'h01;

  // reset values
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic              ZERO_RST  = 1'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

  // decoded operation, one-hot
  typedef enum logic [4:0] {
    OP_NONE  = 5'h01,
    OP_LIT   = 5'h02,
    OP_OR    = 5'h04,
    OP_MOV   = 5'h08,
    OP_STORE = 5'h10
  } maoi_op_t;

  // decoded instruction
  typedef struct packed {
    maoi_op_t          op;
    logic              to_file;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
  } maoi_dec_t;

  // write request towards the file-register array
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } maoi_fwr_t;

endpackage : maoi_pkg

/* File: hw/maoi_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// pure decoder for the four supported instruction words
module maoi_decode (
  input  wire logic [maoi_pkg::INSN_W-1:0] insn_in,
  output var maoi_pkg::maoi_dec_t          dec_out
);

  // classify one word; anything else becomes OP_NONE
  function automatic maoi_pkg::maoi_op_t classify(input logic [maoi_pkg::INSN_W-1:0] w);
    maoi_pkg::maoi_op_t op;
    op = maoi_pkg::OP_NONE;
    if (w[maoi_pkg::INSN_W-1:maoi_pkg::LIT_OPC_LSB] == maoi_pkg::LIT_OPC)
      op = maoi_pkg::OP_LIT;
    else if (w[maoi_pkg::INSN_W-1:maoi_pkg::REG_OPC_LSB] == maoi_pkg::OR_OPC)
      op = maoi_pkg::OP_OR;
    else if (w[maoi_pkg::INSN_W-1:maoi_pkg::REG_OPC_LSB] == maoi_pkg::MOV_OPC)
      op = maoi_pkg::OP_MOV;
    else if (w[maoi_pkg::INSN_W-1:maoi_pkg::STO_OPC_LSB] == maoi_pkg::STO_OPC)
      op = maoi_pkg::OP_STORE;
    return op;
  endfunction : classify

  // field extraction; fields are meaningful only for ops that use them
  always_comb
  begin
    dec_out.op      = classify(insn_in);
    dec_out.to_file = insn_in[maoi_pkg::DIR_BIT];
    dec_out.addr    = insn_in[maoi_pkg::ADDR_LSB +: maoi_pkg::ADDR_W];
    dec_out.lit     = insn_in[maoi_pkg::LIT_LSB +: maoi_pkg::DATA_W];
  end

endmodule : maoi_decode
`default_nettype wire

/* File: hw/maoi_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - literal-load opcode copies the 8-bit immediate into accumulator, flags untouched
// - the two don't-care bits of literal load never change decoding
// - or-with-file ORs accumulator with addressed register and updates zero flag
// - or-with-file direction 0 writes accumulator, direction 1 writes the register
// - move-file reads addressed register and passes it unchanged to destination
// - move-file direction 0 targets accumulator, direction 1 rewrites same register
// - move-file updates zero flag from moved value, making self-move a zero test
// - store opcode writes accumulator into addressed register, flags untouched
module maoi_exec #(
  parameter int INSN_W = 14,
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  input  wire logic                         mclk_in,
  input  wire logic                         nrst_in,
  // instruction from fetch, same clock
  input  wire logic                         insn_valid_in,
  input  wire logic [INSN_W-1:0]            insn_in,
  // file register array read port (combinational read)
  output logic      [ADDR_W-1:0]            file_raddr_out,
  input  wire logic [DATA_W-1:0]            file_rdata_in,
  // file register array write port (registered)
  output logic                              file_we_out,
  output logic      [ADDR_W-1:0]            file_waddr_out,
  output logic      [DATA_W-1:0]            file_wdata_out,
  // architectural state
  output logic      [DATA_W-1:0]            accum_out,
  output logic                              zero_out,
  // retire and unsupported-word pulses
  output logic                              retire_out,
  output logic                              unknown_out
);

  // the encoding is fixed, so only the documented geometry can be served
  if (INSN_W != maoi_pkg::INSN_W || DATA_W != maoi_pkg::DATA_W || ADDR_W != maoi_pkg::ADDR_W)
  begin : g_bad_geometry
    $error("maoi_exec: only 14-bit words, 8-bit data and 7-bit indices are supported");
  end

  maoi_pkg::maoi_dec_t         dec;
  logic [DATA_W-1:0]           opnd;
  logic [DATA_W-1:0]           result;
  logic                        exec_lit;
  logic                        exec_or;
  logic                        exec_mov;
  logic                        exec_sto;

  logic [DATA_W-1:0]           accum_q;
  logic [DATA_W-1:0]           accum_d;
  logic                        zero_q;
  logic                        zero_d;
  maoi_pkg::maoi_fwr_t         fwr_q;
  maoi_pkg::maoi_fwr_t         fwr_d;
  logic                        retire_q;
  logic                        retire_d;
  logic                        unknown_q;
  logic                        unknown_d;

  maoi_decode maoi_decode_i (
    .insn_in (insn_in),
    .dec_out (dec)
  );

  // qualified operation strobes
  assign exec_lit = insn_valid_in && (dec.op == maoi_pkg::OP_LIT);
  assign exec_or  = insn_valid_in && (dec.op == maoi_pkg::OP_OR);
  assign exec_mov = insn_valid_in && (dec.op == maoi_pkg::OP_MOV);
  assign exec_sto = insn_valid_in && (dec.op == maoi_pkg::OP_STORE);

  // read address straight from the word so the array answers in the same cycle
  assign file_raddr_out = dec.addr;

  // the write of the previous instruction lands at the end of this cycle;
  // forward it so back-to-back use of one register sees the new value
  always_comb
  begin
    if (fwr_q.en && (fwr_q.addr == dec.addr))
      opnd = fwr_q.data;
    else
      opnd = file_rdata_in;
  end

  always_comb
  begin
    if (exec_or)
      result = accum_q | opnd;
    else
      result = opnd;
  end

  // next architectural state
  always_comb
  begin
    accum_d   = accum_q;
    zero_d    = zero_q;
    fwr_d.en   = 1'h0;
    fwr_d.addr = dec.addr;
    fwr_d.data = result;
    retire_d  = insn_valid_in;
    unknown_d = insn_valid_in && (dec.op == maoi_pkg::OP_NONE);
    if (exec_lit)
      accum_d = dec.lit;
    if (exec_or || exec_mov)
    begin
      if (dec.to_file)
        fwr_d.en = 1'h1;
      else
        accum_d = result;
      zero_d = (result == maoi_pkg::DATA_ZERO);
    end
    if (exec_sto)
    begin
      fwr_d.en   = 1'h1;
      fwr_d.data = accum_q;
    end
  end

  // every instruction retires in one edge
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      accum_q   <= maoi_pkg::ACCUM_RST;
      zero_q    <= maoi_pkg::ZERO_RST;
      fwr_q     <= '{en: 1'h0, addr: maoi_pkg::ADDR_ZERO, data: maoi_pkg::DATA_ZERO};
      retire_q  <= 1'h0;
      unknown_q <= 1'h0;
    end
    else
    begin
      accum_q   <= accum_d;
      zero_q    <= zero_d;
      fwr_q     <= fwr_d;
      retire_q  <= retire_d;
      unknown_q <= unknown_d;
    end
  end

  // outputs, all from flops
  assign accum_out      = accum_q;
  assign zero_out       = zero_q;
  assign file_we_out    = fwr_q.en;
  assign file_waddr_out = fwr_q.addr;
  assign file_wdata_out = fwr_q.data;
  assign retire_out     = retire_q;
  assign unknown_out    = unknown_q;

  a_lit_loads_accum: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    exec_lit |=> (accum_q == $past(insn_in[maoi_pkg::LIT_LSB +: maoi_pkg::DATA_W]))
      && $stable(zero_q) && !fwr_q.en)
    else $error("literal load did not land in accumulator");

  // don't-care bits, judged on the outcome rather than on the decoder
  a_lit_dontcare: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (insn_valid_in
      && (insn_in[maoi_pkg::INSN_W-1:maoi_pkg::LIT_OPC_LSB] == maoi_pkg::LIT_OPC))
    |=> (accum_q == $past(insn_in[maoi_pkg::LIT_LSB +: maoi_pkg::DATA_W])) && !unknown_q)
    else $error("literal load missed for some don't-care bits");

  a_or_to_accum: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (exec_or && !insn_in[maoi_pkg::DIR_BIT])
      |=> (accum_q == ($past(accum_q) | $past(opnd))) && !fwr_q.en)
    else $error("or result wrong in accumulator");

  a_or_to_file: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (exec_or && insn_in[maoi_pkg::DIR_BIT]) |=> fwr_q.en && $stable(accum_q)
      && (fwr_q.data == ($past(accum_q) | $past(opnd)))
      && (fwr_q.addr == $past(insn_in[maoi_pkg::ADDR_LSB +: maoi_pkg::ADDR_W])))
    else $error("or result not written back to register");

  a_mov_to_accum: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (exec_mov && !insn_in[maoi_pkg::DIR_BIT]) |=> (accum_q == $past(opnd)) && !fwr_q.en)
    else $error("move did not copy register to accumulator");

  a_mov_to_file: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (exec_mov && insn_in[maoi_pkg::DIR_BIT]) |=> fwr_q.en && (fwr_q.data == $past(opnd))
      && (fwr_q.addr == $past(insn_in[maoi_pkg::ADDR_LSB +: maoi_pkg::ADDR_W]))
      && $stable(accum_q))
    else $error("move to register did not rewrite it");

  a_zero_from_move: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    exec_mov |=> (zero_q == ($past(opnd) == maoi_pkg::DATA_ZERO)))
    else $error("zero flag wrong after move");

  a_store_accum: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    exec_sto |=> fwr_q.en && (fwr_q.data == $past(accum_q))
      && (fwr_q.addr == $past(insn_in[maoi_pkg::ADDR_LSB +: maoi_pkg::ADDR_W]))
      && $stable(zero_q) && $stable(accum_q))
    else $error("store did not write accumulator to register");

  // zero flag from or result and single-cycle retire
  a_zero_from_or: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    exec_or |=> (zero_q == (($past(accum_q) | $past(opnd)) == maoi_pkg::DATA_ZERO))
      && retire_out)
    else $error("zero flag or retire wrong after or");

  // a cycle without a word must leave every piece of state alone
  a_idle_holds_state: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !insn_valid_in |=> !retire_q && !unknown_q && !fwr_q.en
      && $stable(accum_q) && $stable(zero_q))
    else $error("state moved without an instruction");

  // an unsupported word only raises its pulse and retire, so it cannot corrupt state
  a_unknown_inert: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (insn_valid_in && (dec.op == maoi_pkg::OP_NONE))
      |=> unknown_q && retire_q && !fwr_q.en && $stable(accum_q) && $stable(zero_q))
    else $error("unsupported word changed state");

endmodule : maoi_exec
`default_nettype wire

/* File: dv/maoi_file_model.sv */
`timescale 1ns/1ps
`default_nettype none
// file-register array model: zero-latency read, write at the edge closing the strobe
module maoi_file_model (
  input  wire logic       mclk_in,
  input  wire logic [6:0] raddr_in,
  output logic      [7:0] rdata_out,
  input  wire logic       we_in,
  input  wire logic [6:0] waddr_in,
  input  wire logic [7:0] wdata_in
);
  logic [7:0] mem_q [0:127];

  // cleared at start so the bench shadow begins from the same contents
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem_q[i] = 8'h00;
  end

  // combinational read, as the exec block expects
  assign rdata_out = mem_q[raddr_in];

  // no write-through: a same-cycle read sees old data, the block must forward
  always @(posedge mclk_in)
  begin
    if (we_in)
      mem_q[waddr_in] <= wdata_in;
  end
endmodule : maoi_file_model
`default_nettype wire

/* File: dv/maoi_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module maoi_exec_tb;
  logic        mclk, nrst, valid, we, retire, unknown, zero, z_e;
  logic [13:0] insn;
  logic [6:0]  raddr, waddr;
  logic [7:0]  rdata, wdata, accum, acc_e;
  logic [7:0]  mem_e [0:127];
  int          failures, comparisons;

  maoi_exec maoi_exec_i (.mclk_in(mclk), .nrst_in(nrst), .insn_valid_in(valid),
    .insn_in(insn), .file_raddr_out(raddr), .file_rdata_in(rdata), .file_we_out(we),
    .file_waddr_out(waddr), .file_wdata_out(wdata), .accum_out(accum), .zero_out(zero),
    .retire_out(retire), .unknown_out(unknown));
  maoi_file_model maoi_file_model_i (.mclk_in(mclk), .raddr_in(raddr), .rdata_out(rdata),
    .we_in(we), .waddr_in(waddr), .wdata_in(wdata));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // issue one word at a falling edge, judge the outcome one cycle later
  task automatic run(input logic [13:0] w);
    logic [7:0] r;
    logic       wr, unk;
    r = mem_e[w[6:0]];
    wr = 1'h0;
    unk = 1'h0;
    if (w[13:10] == 4'hC)
      acc_e = w[7:0];
    else if (w[13:8] == 6'h04 || w[13:8] == 6'h08)
    begin
      if (w[13:8] == 6'h04)
        r = r | acc_e;
      z_e = (r == 8'h00);
      wr = w[7];
      if (w[7])
        mem_e[w[6:0]] = r;
      else
        acc_e = r;
    end
    else if (w[13:7] == 7'h01)
    begin
      r = acc_e;
      wr = 1'h1;
      mem_e[w[6:0]] = acc_e;
    end
    else
      unk = 1'h1;
    valid = 1'h1;
    insn = w;
    @(negedge mclk);
    check("state", {4'h0, 1'h1, unk, wr, z_e, acc_e}, {4'h0, retire, unknown, we, zero, accum});
    if (wr)
      check("write", {1'h0, w[6:0], r}, {1'h0, waddr, wdata});
  endtask : run

  // quiet cycle closes a test: no retire, no write
  task automatic idle(input string name);
    valid = 1'h0;
    @(negedge mclk);
    check("idle", 16'h0000, {13'h0000, retire, unknown, we});
    $display("done %s", name);
  endtask : idle

  task automatic t_literal();
    run(14'h0885);
    for (int d = 0; d < 4; d++)
      run({4'hC, d[1:0], 8'h5A ^ 8'(d)});
    idle("literal");
  endtask : t_literal

  task automatic t_or();
    run(14'h3013);
    run(14'h00A0);
    run(14'h3091);
    run(14'h0420);
    run(14'h04A0);
    run(14'h0820);
    run(14'h3000);
    run(14'h0405);
    idle("or");
  endtask : t_or

  task automatic t_move();
    run(14'h08A0);
    run(14'h08A5);
    run(14'h3077);
    run(14'h0805);
    idle("move");
  endtask : t_move

  task automatic t_store();
    run(14'h304F);
    run(14'h00FF);
    run(14'h0080);
    run(14'h3000);
    run(14'h087F);
    idle("store");
  endtask : t_store

  task automatic t_unknown();
    run(14'h0000);
    run(14'h3835);
    idle("unknown");
  endtask : t_unknown

  // reset in mid-run: accumulator and flags return to reset values, array keeps its words;
  // the or afterwards only matches if the accumulator really went back to zero
  task automatic t_reset();
    run(14'h30A5);
    nrst = 1'h0;
    valid = 1'h0;
    @(negedge mclk);
    check("reset mid", 16'h0000, {4'h0, retire, unknown, we, zero, accum});
    acc_e = 8'h00;
    z_e = 1'h0;
    nrst = 1'h1;
    @(negedge mclk);
    run(14'h047F);
    idle("reset");
  endtask : t_reset

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // whole run is well under 100 cycles; cut a hang at 2000
  initial
  begin
    repeat (2000) @(posedge mclk);
    failures++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'h0;
    valid = 1'h0;
    insn = 14'h0000;
    failures = 0;
    comparisons = 0;
    acc_e = 8'h00;
    z_e = 1'h0;
    for (int i = 0; i < 128; i++)
      mem_e[i] = 8'h00;
    repeat (12) @(negedge mclk);
    check("reset", 16'h0000, {4'h0, retire, unknown, we, zero, accum});
    nrst = 1'h1;
    @(negedge mclk);
    t_literal();
    t_or();
    t_move();
    t_store();
    t_unknown();
    t_reset();
    wrap_up();
  end
endmodule : maoi_exec_tb
`default_nettype wire
